// ===== verilog/amr_regs.svh
// offsets, field positions, reset value and counts of the mode register
`ifndef AMR_REGS_SVH
`define AMR_REGS_SVH
// Summary of operation
// - 24-bit read/write register, select code 001
// - reset loads 0x080060
// - shifted most significant bit first
// - write restarts modulator, filter with a one-cycle pulse
// - bits 23:21 choose the operating mode
// - bit 20 appends status to data reads
// - bits 19:18 choose the clock source
// - field layout; bit 14 always reads 0
// - bits 9:0 set the output data rate
// - clock codes: crystal, external, internal, driven
// - parity flag tracks odd ones in data
// - data read is 24 or 32 bits
// ============================================================
// register select and reset value
`define AMR_REG_SEL      3'h1
`define AMR_WIDTH        24
`define AMR_RESET        24'h080060
// ============================================================
// field positions
`define AMR_MODE_HI      23
`define AMR_MODE_LO      21
`define AMR_APPEND_BIT   20
`define AMR_CLK_HI       19
`define AMR_CLK_LO       18
`define AMR_AVG_HI       17
`define AMR_AVG_LO       16
`define AMR_THIRD_ORDER_FILTER_SEL_BIT    15
`define AMR_ZERO_BIT     14
`define AMR_PARITY_BIT   13
`define AMR_CLKDIV_BIT   12
`define AMR_SINGLE_BIT   11
`define AMR_SIXTY_HERTZ_NOTCH_ENABLE_BIT    10
`define AMR_FW_HI        9
`define AMR_FW_LO        0
// ============================================================
// clock source codes and data read lengths
`define AMR_CLK_XTAL     2'h0
`define AMR_CLK_EXT      2'h1
`define AMR_CLK_INT      2'h2
`define AMR_CLK_INT_OUT  2'h3
`define AMR_READ_SHORT   6'h18
`define AMR_READ_LONG    6'h20
`define AMR_LAST_BIT     5'h17
`endif

// ===== verilog/amr_pkg.sv
// types shared by the mode register block
package amr_pkg;
  // ============================================================
  // state of the mode register block apart from the pin synchroniser
  typedef struct packed {
    logic        sclk_q;
    logic [23:0] shreg;
    logic [4:0]  bitcnt;
    logic        active;
    logic [23:0] mode;
    logic        dout;
    logic        restart;
    logic        parity;
    logic        xtal_en;
    logic        clk2_oe;
    logic        int_clk;
    logic [5:0]  read_bits;
  } amr_state_t;
endpackage : amr_pkg

// ===== verilog/amr_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/100ps
module amr_sync #(
  parameter int W = 3
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         nrst_i,
  // raw and synchronised levels
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  typedef struct packed {
    logic [W-1:0] s2;
    logic [W-1:0] s1;
  } amr_sync_t;

  amr_sync_t r;
  amr_sync_t next_r;

  // first stage feeds only the second
  always_comb
  begin
    next_r.s1 = d_i;
    next_r.s2 = r.s1;
  end

  // idle-high reset value suits chip select and clock
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      r <= '1;
    else
      r <= next_r;
  end

  assign q_o = r.s2;
endmodule : amr_sync

// ===== verilog/amr_mode_reg.sv
// mode register with its serial shift path and decoded controls
`timescale 1ns/100ps
`include "amr_regs.svh"
module amr_mode_reg
  import amr_pkg::*;
(
  // clock and reset
  input  wire logic        CLK_I,
  input  wire logic        NRST_I,
  // serial pins
  input  wire logic        SCLK_I,
  input  wire logic        CS_N_I,
  input  wire logic        DIN_I,
  output logic             DOUT_O,
  // access control from the communications logic
  input  wire logic        ACCESS_I,
  input  wire logic [2:0]  REG_SEL_I,
  input  wire logic        REG_WRITE_I,
  // data register contents for the parity check
  input  wire logic [23:0] DATA_WORD_I,
  // register contents and fields
  output logic [23:0]      MODE_REG_O,
  output logic [2:0]       OP_MODE_O,
  output logic             APPEND_STATUS_O,
  output logic [9:0]       FILTER_WORD_O,
  output logic [5:0]       DATA_READ_BITS_O,
  // side effects and flags
  output logic             RESTART_O,
  output logic             PARITY_FLAG_O,
  // clock source controls
  output logic             CRYSTAL_EN_O,
  output logic             INTERNAL_CLK_O,
  output logic             SECOND_CLOCK_PIN_OE_O
);
  amr_state_t r;
  amr_state_t next_r;
  logic [2:0] pins_s;
  logic       sclk_s;
  logic       cs_n_s;
  logic       din_s;
  logic       rise;
  logic       fall;

  // ============================================================
  // select decode, used by reads and writes alike
  function automatic logic sel_mode(input logic [2:0] sel);
    sel_mode = (sel == `AMR_REG_SEL);
  endfunction : sel_mode

  // ============================================================
  // pins are asynchronous to the converter clock
  amr_sync #(
    .W (3)
  ) u_sync (
    .clk_i  (CLK_I),
    .nrst_i (NRST_I),
    .d_i    ({SCLK_I, CS_N_I, DIN_I}),
    .q_o    (pins_s)
  );
  assign sclk_s = pins_s[2];
  assign cs_n_s = pins_s[1];
  assign din_s  = pins_s[0];
  assign rise   = sclk_s & ~r.sclk_q;
  assign fall   = ~sclk_s & r.sclk_q;

  // ============================================================
  // next state: shift path, load and decoded controls
  always_comb
  begin
    next_r         = r;
    next_r.restart = 1'b0;
    next_r.sclk_q  = sclk_s;
    if (cs_n_s || !ACCESS_I || !sel_mode(REG_SEL_I))
    begin
      next_r.active = 1'b0;
      next_r.bitcnt = 5'h0;
    end
    else if (!r.active)
    begin
      // first bit out is bit 23
      next_r.active = 1'b1;
      next_r.bitcnt = 5'h0;
      next_r.shreg  = r.mode;
      next_r.dout   = r.mode[`AMR_MODE_HI];
    end
    else
    begin
      if (rise && r.bitcnt <= `AMR_LAST_BIT)
      begin
        next_r.shreg  = {r.shreg[22:0], din_s};
        next_r.bitcnt = r.bitcnt + 5'h1;
        // partial writes never touch the register
        if (REG_WRITE_I && r.bitcnt == `AMR_LAST_BIT)
        begin
          next_r.mode    = {r.shreg[22:0], din_s};
          next_r.mode[`AMR_ZERO_BIT] = 1'b0;
          next_r.restart = 1'b1;
        end
      end
      if (fall && !REG_WRITE_I)
        next_r.dout = r.shreg[`AMR_MODE_HI];
    end
    // controls follow the stored fields
    next_r.xtal_en = (next_r.mode[`AMR_CLK_HI:`AMR_CLK_LO]
                      == `AMR_CLK_XTAL);
    next_r.int_clk = next_r.mode[`AMR_CLK_HI];
    next_r.clk2_oe = (next_r.mode[`AMR_CLK_HI:`AMR_CLK_LO]
                      == `AMR_CLK_INT_OUT);
    next_r.read_bits = next_r.mode[`AMR_APPEND_BIT] ? `AMR_READ_LONG
                                                    : `AMR_READ_SHORT;
    next_r.parity = next_r.mode[`AMR_PARITY_BIT] & (^DATA_WORD_I);
  end

  // ============================================================
  // state register; reset value loads the defaults
  always_ff @(posedge CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      r           <= '0;
      r.sclk_q    <= 1'b1;
      r.mode      <= `AMR_RESET;
      r.int_clk   <= 1'b1;
      r.read_bits <= `AMR_READ_SHORT;
    end
    else
      r <= next_r;
  end

  // ============================================================
  // outputs are flop bits or slices of them
  assign DOUT_O                = r.dout;
  assign MODE_REG_O            = r.mode;
  assign OP_MODE_O             = r.mode[`AMR_MODE_HI:`AMR_MODE_LO];
  assign APPEND_STATUS_O       = r.mode[`AMR_APPEND_BIT];
  assign FILTER_WORD_O         = r.mode[`AMR_FW_HI:`AMR_FW_LO];
  assign DATA_READ_BITS_O      = r.read_bits;
  assign RESTART_O             = r.restart;
  assign PARITY_FLAG_O         = r.parity;
  assign CRYSTAL_EN_O          = r.xtal_en;
  assign INTERNAL_CLK_O        = r.int_clk;
  assign SECOND_CLOCK_PIN_OE_O = r.clk2_oe;

  // ============================================================
  // checks
  sequence last_write_bit;
    r.active && REG_WRITE_I && rise && r.bitcnt == `AMR_LAST_BIT;
  endsequence

  sequence restart_pulse;
    RESTART_O ##1 !RESTART_O;
  endsequence

  chk_reset_value: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    !$past(NRST_I) |-> MODE_REG_O == `AMR_RESET)
    else $error("mode register reset value wrong");

  chk_write_restart: assert property (@(posedge CLK_I)
    disable iff (!NRST_I) last_write_bit |=> restart_pulse)
    else $error("full write did not give one restart pulse");

  chk_full_write: assert property (@(posedge CLK_I)
    disable iff (!NRST_I) !RESTART_O |-> $stable(MODE_REG_O))
    else $error("mode register changed without a full write");

  chk_sel_code: assert property (@(posedge CLK_I)
    disable iff (!NRST_I) RESTART_O |-> $past(REG_SEL_I) == `AMR_REG_SEL)
    else $error("write taken for another register");

  chk_bit_zero: assert property (@(posedge CLK_I)
    disable iff (!NRST_I) RESTART_O |-> !MODE_REG_O[`AMR_ZERO_BIT])
    else $error("bit 14 not held at zero");

  chk_msb_first: assert property (@(posedge CLK_I)
    disable iff (!NRST_I) $rose(r.active) |-> DOUT_O == MODE_REG_O[23])
    else $error("read does not start with bit 23");

  chk_parity_flag: assert property (@(posedge CLK_I)
    disable iff (!NRST_I)
    1'b1 |=> PARITY_FLAG_O == (MODE_REG_O[13] & (^$past(DATA_WORD_I))))
    else $error("parity flag does not track data");

  chk_read_len: assert property (@(posedge CLK_I)
    disable iff (!NRST_I) $changed(APPEND_STATUS_O) |->
    DATA_READ_BITS_O == (APPEND_STATUS_O ? 6'h20 : 6'h18))
    else $error("read length does not follow append bit");

  chk_clock_pins: assert property (@(posedge CLK_I)
    disable iff (!NRST_I) SECOND_CLOCK_PIN_OE_O |->
    INTERNAL_CLK_O && !CRYSTAL_EN_O && MODE_REG_O[18])
    else $error("clock pin drive with wrong source");
endmodule : amr_mode_reg

// ===== test/amr_host.sv
// host side model that drives the serial pins of the mode register
`timescale 1ns/100ps
module amr_host (
  // clock
  input  wire logic CLK_I,
  // serial pins
  output logic      SCLK_O,
  output logic      CS_N_O,
  output logic      DIN_O,
  input  wire logic DOUT_I
);
  // pins idle with the clock high and the device deselected
  initial
  begin
    SCLK_O = 1'b1;
    CS_N_O = 1'b1;
    DIN_O  = 1'b0;
  end
  // n bits msb first; low and high phases of 4 cycles clear the sync delay
  task automatic xfer(input logic [23:0] wd, input int n,
                      output logic [23:0] rd);
    rd = 24'h0;
    @(posedge CLK_I) CS_N_O <= 1'b0;
    repeat (6) @(posedge CLK_I);
    for (int i = 23; i > 23 - n; i--)
    begin
      DIN_O  <= wd[i];
      SCLK_O <= 1'b0;
      repeat (4) @(posedge CLK_I);
      // sample at the rise: the fall has moved DOUT to this bit by now
      rd[i]  = DOUT_I;
      SCLK_O <= 1'b1;
      repeat (4) @(posedge CLK_I);
    end
    CS_N_O <= 1'b1;
    DIN_O  <= ~DIN_O; // released line must not keep the last bit
    repeat (4) @(posedge CLK_I);
  endtask : xfer
endmodule : amr_host

// ===== test/amr_mode_reg_bench.sv
// self-checking bench for the mode register block
`timescale 1ns/100ps
module amr_mode_reg_bench;
  // ============================================================
  // stimulus and observed signals
  logic        clk_i = 1'b0;
  logic        nrst_i;
  logic        access = 1'b0;
  logic [2:0]  sel = 3'h1;
  logic        wr = 1'b0;
  logic [23:0] data_word = 24'h0;
  logic        sclk, cs_n, din, dout, append, restart, parity;
  logic        xtal, intclk, oe;
  logic [23:0] mode, rd, exp;
  logic [2:0]  op_mode;
  logic [9:0]  fw;
  logic [5:0]  rbits;
  int          num_errors = 0;
  int          samples_checked = 0;
  int          pulses = 0;
  int          p0;
  always #4 clk_i = ~clk_i;
  // restart is a one-cycle pulse, so counting cycles counts writes
  always @(posedge clk_i) if (restart === 1'b1) pulses <= pulses + 1;
  amr_host u_amr_host (.CLK_I(clk_i), .SCLK_O(sclk), .CS_N_O(cs_n),
    .DIN_O(din), .DOUT_I(dout));
  amr_mode_reg u_amr_mode_reg (.CLK_I(clk_i), .NRST_I(nrst_i),
    .SCLK_I(sclk), .CS_N_I(cs_n), .DIN_I(din), .DOUT_O(dout),
    .ACCESS_I(access), .REG_SEL_I(sel), .REG_WRITE_I(wr),
    .DATA_WORD_I(data_word), .MODE_REG_O(mode), .OP_MODE_O(op_mode),
    .APPEND_STATUS_O(append), .FILTER_WORD_O(fw),
    .DATA_READ_BITS_O(rbits), .RESTART_O(restart),
    .PARITY_FLAG_O(parity), .CRYSTAL_EN_O(xtal),
    .INTERNAL_CLK_O(intclk), .SECOND_CLOCK_PIN_OE_O(oe));
  // ============================================================
  // compare, report and transfer tasks
  task automatic check(input string name, input logic [23:0] seen,
                       input logic [23:0] want);
    samples_checked++;
    if (seen !== want)
    begin
      num_errors++;
      $display("Error %s expected %h seen %h", name, want, seen);
    end
  endtask : check
  task automatic summarize();
    $display("checked %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : summarize
  // access is dropped between transfers so each one opens afresh
  task automatic xs(input logic [2:0] s, input logic w,
                    input logic [23:0] wd, input int n);
    @(posedge clk_i);
    access <= 1'b1;
    sel    <= s;
    wr     <= w;
    u_amr_host.xfer(wd, n, rd);
    access <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask : xs
  // hang guard
  initial
  begin
    repeat (100000) @(posedge clk_i);
    num_errors++;
    summarize();
  end
  // ============================================================
  // main sequence
  initial
  begin
    // driven, not initialised, so the reset flops see a falling edge
    nrst_i <= 1'b0;
    repeat (20) @(posedge clk_i);
    nrst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    check("reset", mode, 24'h080060);
    check("rbits", {18'h0, rbits}, 24'h000018);
    check("clk", {21'h0, xtal, intclk, oe}, 24'h000002);
    xs(3'h1, 1'b0, 24'h0, 24);
    check("read", rd, 24'h080060);
    for (int c = 0; c < 4; c++)
    begin
      p0  = pulses;
      exp = {3'h5, 1'b1, c[1:0], 2'h3, 16'hFEA5};
      xs(3'h1, 1'b1, exp, 24);
      exp[14] = 1'b0;
      check("mode", mode, exp);
      check("pulse", 24'(pulses - p0), 24'h1);
      check("fields", {op_mode, append, rbits, fw, 4'h0},
            {3'h5, 1'b1, 6'h20, 10'h2A5, 4'h0});
      check("clk", {21'h0, xtal, intclk, oe},
            {21'h0, c == 0, c[1], c == 3});
      xs(3'h1, 1'b0, 24'h0, 24);
      check("read", rd, exp);
    end
    data_word <= 24'h000007;
    repeat (3) @(posedge clk_i);
    check("par_odd", {23'h0, parity}, 24'h1);
    data_word <= 24'h000003;
    repeat (3) @(posedge clk_i);
    check("par_even", {23'h0, parity}, 24'h0);
    // a cut-short write and a foreign select must leave no trace
    p0 = pulses;
    xs(3'h1, 1'b1, 24'h0, 12);
    xs(3'h2, 1'b1, 24'h0, 24);
    check("abort", mode, exp);
    check("nopulse", 24'(pulses - p0), 24'h0);
    // reset in mid-run must bring the defaults back
    nrst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    nrst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    check("rst2", mode, 24'h080060);
    check("rst2_clk", {21'h0, xtal, intclk, oe}, 24'h000002);
    data_word <= 24'h000007;
    xs(3'h1, 1'b1, 24'h080060, 24);
    check("back", {op_mode, append, rbits, fw, 4'h0},
          {3'h0, 1'b0, 6'h18, 10'h060, 4'h0});
    check("par_off", {23'h0, parity}, 24'h0);
    summarize();
  end
endmodule : amr_mode_reg_bench
